// ### core/flash_seq_defs.svh
// Register offsets, field positions, reset values and timing counts
// for the table access flash sequencer.
// Assumes a 20 MHz system clock and word-aligned AXI4-Lite access.
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_PTR_LOW 8'h00
`define OFF_PTR_HIGH 8'h04
`define OFF_PTR_UPPER 8'h08
`define OFF_LATCH 8'h0C
`define OFF_CTRL 8'h10
`define OFF_KEY 8'h14
`define OFF_OP 8'h18
`define OFF_STATUS 8'h1C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_PROG_SEL 7
`define CTL_CFG_SEL 6
`define CTL_ROW_ERASE 4
`define CTL_ABORTED 3
`define CTL_PERMIT 2
`define CTL_START 1
`define CTL_WMASK 8'hD4

// ----------------------------------------
// Operation port fields
// ----------------------------------------
`define OP_STORE 2
`define OP_MODE_LSB 0

// ----------------------------------------
// Unlock keys and reset values
// ----------------------------------------
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define CTRL_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 20000000
`define LONG_CYCLE_US 2000
`define LONG_CYCLE_CYCLES ((`CLK_HZ / 1000000) * `LONG_CYCLE_US)

`endif

// ### core/flash_seq_pkg.sv
// Types shared by the flash sequencer files.
// Assumes the defines header is compiled alongside.
package flash_seq_pkg;
    typedef enum logic [1:0]
    {
        PTR_KEEP,
        PTR_POST_INC,
        PTR_POST_DEC,
        PTR_PRE_INC
    } ptr_mode_t;

    typedef enum logic [1:0]
    {
        LONG_NONE,
        LONG_PROGRAM,
        LONG_ERASE
    } long_kind_t;
endpackage

// ### core/ptr_step.sv
// Pointer update for table fetch and store operations.
// Assumes a 22-bit pointer whose top bit selects the configuration space.
`timescale 1ns/10ps

module ptr_step #(
    parameter int LOW_W = 21
)(
    input wire logic [LOW_W:0] ptr_in,
    input wire flash_seq_pkg::ptr_mode_t mode,
    output logic [LOW_W:0] access_addr,
    output logic [LOW_W:0] ptr_next
);
    logic [LOW_W-1:0] inc_low;
    logic [LOW_W-1:0] dec_low;

    // Wraps inside the low field, never touching the space bit
    assign inc_low = ptr_in[LOW_W-1:0] + 1'b1;
    assign dec_low = ptr_in[LOW_W-1:0] - 1'b1;

    always_comb
    begin
        access_addr = ptr_in;
        ptr_next = ptr_in;
        case (mode)
            flash_seq_pkg::PTR_KEEP:
            begin
                ptr_next = ptr_in;
            end
            flash_seq_pkg::PTR_POST_INC:
            begin
                ptr_next = {ptr_in[LOW_W], inc_low};
            end
            flash_seq_pkg::PTR_POST_DEC:
            begin
                ptr_next = {ptr_in[LOW_W], dec_low};
            end
            flash_seq_pkg::PTR_PRE_INC:
            begin
                access_addr = {ptr_in[LOW_W], inc_low};
                ptr_next = {ptr_in[LOW_W], inc_low};
            end
            default:
            begin
                ptr_next = ptr_in;
            end
        endcase
    end
endmodule // ptr_step

// ### core/long_timer.sv
// Countdown timer for the self-timed erase and program cycles.
// Assumes start is a one-cycle pulse while the timer is idle.
`timescale 1ns/10ps

module long_timer #(
    parameter int CYCLES = 40000
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [$clog2(CYCLES+1)-1:0] count_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_q <= '0;
        end
        else if (start)
        begin
            count_q <= ($clog2(CYCLES+1))'(CYCLES);
        end
        else if (count_q != '0)
        begin
            count_q <= count_q - 1'b1;
        end
    end

    assign busy = (count_q != '0);
    assign done = (count_q == ($clog2(CYCLES+1))'(1));
endmodule // long_timer

// ### core/table_access_flash_sequencer.sv
// Table access flash sequencer: pointer, transfer latch, holding
// registers, unlocked erase and program cycles, AXI4-Lite registers.
// Assumes the flash array answers a word read combinationally and
// accepts a one-cycle program or erase command; the core obeys halt.
`timescale 1ns/10ps

`include "flash_seq_defs.svh"

module table_access_flash_sequencer #(
    parameter int ADDR_W = 22,
    parameter int LONG_CYCLES = `LONG_CYCLE_CYCLES
)(
    input wire logic clk,
    input wire logic rst,
    // Resets that may cut a running cycle, sampled before rst acts
    input wire logic ext_reset_req,
    input wire logic wdt_reset_req,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core side
    output logic core_halt,
    output logic cycle_done_irq_flag,
    // Flash array side
    output logic [ADDR_W-2:0] flash_word_addr,
    input wire logic [15:0] flash_word_data,
    output logic flash_program,
    output logic flash_erase,
    output logic [ADDR_W-1:0] flash_block_addr,
    output logic [63:0] flash_block_data
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [ADDR_W-1:0] flash_byte_pointer_q;
    logic [7:0] transfer_byte_latch_q;
    logic [7:0] hold_q [8];
    logic program_space_select_q;
    logic config_space_select_q;
    logic row_erase_q;
    logic aborted_cycle_flag_q;
    logic modify_permit_q;
    logic start_q;
    logic [1:0] key_stage_q;
    flash_seq_pkg::long_kind_t kind_q;
    logic [7:0] aw_addr_q;
    logic aw_full_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_full_q;

    // ----------------------------------------
    // Write path
    // ----------------------------------------
    logic wr_fire;
    logic wr_lane0;
    logic [7:0] wr_byte;
    logic [ADDR_W-1:0] access_addr;
    logic [ADDR_W-1:0] ptr_next;
    flash_seq_pkg::ptr_mode_t op_mode;
    logic op_fire;
    logic op_store;
    logic start_req;
    logic start_ok;
    logic timer_busy;
    logic timer_done;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        is_reg = (a == off);
    endfunction

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_lane0 = wr_fire && w_strb_q[0];
    assign wr_byte = w_data_q[7:0];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Unmapped writes get SLVERR; mapped ones OKAY
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_bresp <= 2'h0;
        end
        else if (wr_fire)
        begin
            s_axi_bresp <= (aw_addr_q > `OFF_STATUS || aw_addr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
        end
    end

    // ----------------------------------------
    // Table operations
    // ----------------------------------------
    assign op_fire = wr_lane0 && is_reg(aw_addr_q, `OFF_OP);
    assign op_mode = flash_seq_pkg::ptr_mode_t'(wr_byte[`OP_MODE_LSB +: 2]);
    assign op_store = wr_byte[`OP_STORE];

    ptr_step #(
        .LOW_W(ADDR_W-1)
    ) u_ptr_step (
        .ptr_in(flash_byte_pointer_q),
        .mode(op_mode),
        .access_addr(access_addr),
        .ptr_next(ptr_next)
    );

    assign flash_word_addr = access_addr[ADDR_W-1:1];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flash_byte_pointer_q <= '0;
        end
        else if (op_fire && !timer_busy)
        begin
            flash_byte_pointer_q <= ptr_next;
        end
        else if (wr_fire && !timer_busy)
        begin
            if (w_strb_q[0] && is_reg(aw_addr_q, `OFF_PTR_LOW))
            begin
                flash_byte_pointer_q[7:0] <= wr_byte;
            end
            if (w_strb_q[0] && is_reg(aw_addr_q, `OFF_PTR_HIGH))
            begin
                flash_byte_pointer_q[15:8] <= wr_byte;
            end
            if (w_strb_q[0] && is_reg(aw_addr_q, `OFF_PTR_UPPER))
            begin
                flash_byte_pointer_q[ADDR_W-1:16] <= wr_byte[ADDR_W-17:0];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            transfer_byte_latch_q <= 8'h00;
        end
        else if (op_fire && !op_store && !timer_busy)
        begin
            transfer_byte_latch_q <= access_addr[0] ? flash_word_data[15:8]
                                                    : flash_word_data[7:0];
        end
        else if (wr_lane0 && is_reg(aw_addr_q, `OFF_LATCH) && !timer_busy)
        begin
            transfer_byte_latch_q <= wr_byte;
        end
    end

    // Stores touch only the holding registers and the pointer
    for (genvar g = 0; g < 8; g++)
    begin : g_hold
        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                hold_q[g] <= 8'hFF;
            end
            else if (op_fire && op_store && !timer_busy && access_addr[2:0] == 3'(g))
            begin
                hold_q[g] <= transfer_byte_latch_q;
            end
        end
        assign flash_block_data[g*8 +: 8] = hold_q[g];
    end

    // ----------------------------------------
    // Unlock and control
    // ----------------------------------------
    // Any other write between the keys and the start breaks the unlock
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            key_stage_q <= 2'h0;
        end
        else if (wr_fire)
        begin
            if (wr_lane0 && is_reg(aw_addr_q, `OFF_KEY) && wr_byte == `KEY_FIRST)
            begin
                key_stage_q <= 2'h1;
            end
            else if (wr_lane0 && is_reg(aw_addr_q, `OFF_KEY) && wr_byte == `KEY_SECOND
                     && key_stage_q == 2'h1)
            begin
                key_stage_q <= 2'h2;
            end
            else
            begin
                key_stage_q <= 2'h0;
            end
        end
    end

    assign start_req = wr_lane0 && is_reg(aw_addr_q, `OFF_CTRL) && wr_byte[`CTL_START];
    assign start_ok = start_req && key_stage_q == 2'h2 && modify_permit_q && !start_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            program_space_select_q <= 1'b0;
            config_space_select_q <= 1'b0;
            modify_permit_q <= 1'b0;
        end
        else if (wr_lane0 && is_reg(aw_addr_q, `OFF_CTRL) && !timer_busy)
        begin
            program_space_select_q <= wr_byte[`CTL_PROG_SEL];
            config_space_select_q <= wr_byte[`CTL_CFG_SEL];
            modify_permit_q <= wr_byte[`CTL_PERMIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            row_erase_q <= 1'b0;
        end
        else if (timer_done && kind_q == flash_seq_pkg::LONG_ERASE)
        begin
            row_erase_q <= 1'b0;
        end
        else if (wr_lane0 && is_reg(aw_addr_q, `OFF_CTRL) && !timer_busy)
        begin
            row_erase_q <= wr_byte[`CTL_ROW_ERASE];
        end
    end

    // Software can only set start; hardware clears it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            start_q <= 1'b0;
            kind_q <= flash_seq_pkg::LONG_NONE;
        end
        else if (timer_done)
        begin
            start_q <= 1'b0;
            kind_q <= flash_seq_pkg::LONG_NONE;
        end
        else if (start_ok)
        begin
            start_q <= 1'b1;
            if (program_space_select_q && modify_permit_q && row_erase_q)
            begin
                kind_q <= flash_seq_pkg::LONG_ERASE;
            end
            else
            begin
                kind_q <= flash_seq_pkg::LONG_PROGRAM;
            end
        end
    end

    // Flag survives rst while ext_reset_req or wdt_reset_req is high: the abort reset is what causes it
    always_ff @(posedge clk)
    begin
        if ((ext_reset_req || wdt_reset_req) && start_q)
        begin
            aborted_cycle_flag_q <= 1'b1;
        end
        else if (wr_lane0 && is_reg(aw_addr_q, `OFF_CTRL) && !wr_byte[`CTL_ABORTED])
        begin
            aborted_cycle_flag_q <= 1'b0;
        end
        else if (rst && !ext_reset_req && !wdt_reset_req)
        begin
            aborted_cycle_flag_q <= 1'b0;
        end
    end

    // Set beats a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cycle_done_irq_flag <= 1'b0;
        end
        else if (timer_done)
        begin
            cycle_done_irq_flag <= 1'b1;
        end
        else if (wr_lane0 && is_reg(aw_addr_q, `OFF_STATUS) && wr_byte[0])
        begin
            cycle_done_irq_flag <= 1'b0;
        end
    end

    long_timer #(
        .CYCLES(LONG_CYCLES)
    ) u_long_timer (
        .clk(clk),
        .rst(rst),
        .start(start_ok),
        .busy(timer_busy),
        .done(timer_done)
    );

    assign core_halt = timer_busy;
    assign flash_program = timer_done && kind_q == flash_seq_pkg::LONG_PROGRAM;
    assign flash_erase = timer_done && kind_q == flash_seq_pkg::LONG_ERASE;
    assign flash_block_addr = (kind_q == flash_seq_pkg::LONG_ERASE)
        ? {flash_byte_pointer_q[ADDR_W-1:6], 6'h00}
        : {flash_byte_pointer_q[ADDR_W-1:3], 3'h0};

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] ctrl_view;

    assign ctrl_view = {program_space_select_q, config_space_select_q, 1'b0, row_erase_q,
                        aborted_cycle_flag_q, modify_permit_q, start_q, 1'b0};
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
            case (s_axi_araddr)
                `OFF_PTR_LOW: s_axi_rdata[7:0] <= flash_byte_pointer_q[7:0];
                `OFF_PTR_HIGH: s_axi_rdata[7:0] <= flash_byte_pointer_q[15:8];
                `OFF_PTR_UPPER: s_axi_rdata[ADDR_W-17:0] <= flash_byte_pointer_q[ADDR_W-1:16];
                `OFF_LATCH: s_axi_rdata[7:0] <= transfer_byte_latch_q;
                `OFF_CTRL: s_axi_rdata[7:0] <= ctrl_view;
                `OFF_KEY, `OFF_OP: s_axi_rdata[7:0] <= 8'h00;
                `OFF_STATUS: s_axi_rdata[0] <= cycle_done_irq_flag;
                default: s_axi_rresp <= 2'h2;
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // table_access_flash_sequencer

// ### verification/flash_seq_checker.sv
// Port-level checks for the flash sequencer.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps

module flash_seq_checker #(
    parameter int ADDR_W = 22,
    parameter int LONG_CYCLES = 16
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic core_halt,
    input wire logic cycle_done_irq_flag,
    input wire logic flash_program,
    input wire logic flash_erase,
    input wire logic [ADDR_W-1:0] flash_block_addr
);
    int halt_cnt_q;
    logic pulse;

    assign pulse = flash_program | flash_erase;

    // Counts halt cycles already passed
    always_ff @(posedge clk)
    begin
        if (rst || !core_halt)
            halt_cnt_q <= 0;
        else
            halt_cnt_q <= halt_cnt_q + 1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    pulse_on_last_a: assert property (pulse |-> core_halt && halt_cnt_q == LONG_CYCLES - 1)
        else $error("array command not on last halt cycle");
    halt_held_a: assert property (core_halt && halt_cnt_q < LONG_CYCLES - 1 |=> core_halt)
        else $error("halt ended early");
    halt_release_a: assert property (pulse |=> !core_halt)
        else $error("halt outlasts the cycle");
    done_cause_a: assert property ($rose(cycle_done_irq_flag) |-> $past(pulse))
        else $error("done flag set without completion");
    done_sticky_a: assert property ($fell(cycle_done_irq_flag) && !$past(rst) |->
        $past(s_axi_wvalid && s_axi_wdata[0], 1) || $past(s_axi_wvalid && s_axi_wdata[0], 2)
        || $past(s_axi_wvalid && s_axi_wdata[0], 3))
        else $error("done flag dropped by itself");
    prog_align_a: assert property (flash_program |-> flash_block_addr[2:0] == 3'h0)
        else $error("program block not 8-byte aligned");
    erase_align_a: assert property (flash_erase |-> flash_block_addr[5:0] == 6'h00)
        else $error("erase row not 64-byte aligned");
    one_kind_a: assert property (pulse |-> !(flash_program && flash_erase) ##1 !pulse)
        else $error("array command mixed or stretched");
    halt_cause_a: assert property ($rose(core_halt) |-> $past(s_axi_wvalid, 1)
        || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
        else $error("halt without a register write");
endmodule // flash_seq_checker

bind table_access_flash_sequencer flash_seq_checker #(
    .ADDR_W(ADDR_W),
    .LONG_CYCLES(LONG_CYCLES)
) u_flash_seq_checker (.clk, .rst, .s_axi_wdata, .s_axi_wvalid, .core_halt,
    .cycle_done_irq_flag, .flash_program, .flash_erase, .flash_block_addr);

// ### verification/flash_array_model.sv
// Behavioural flash array facing the sequencer.
// Assumes word reads are combinational and commands are one-cycle pulses.
`timescale 1ns/10ps

module flash_array_model (
    input wire logic clk,
    input wire logic [20:0] flash_word_addr,
    output logic [15:0] flash_word_data,
    input wire logic flash_program,
    input wire logic flash_erase,
    input wire logic [21:0] flash_block_addr,
    input wire logic [63:0] flash_block_data,
    output int prog_cnt,
    output int erase_cnt,
    output logic [21:0] last_addr,
    output logic [63:0] last_data
);
    // Lanes differ so a swapped byte select shows
    assign flash_word_data = {~flash_word_addr[7:0], flash_word_addr[7:0]};

    initial
    begin
        prog_cnt = 0;
        erase_cnt = 0;
    end

    always @(posedge clk)
    begin
        if (flash_program)
        begin
            prog_cnt <= prog_cnt + 1;
            last_data <= flash_block_data;
        end
        if (flash_erase)
            erase_cnt <= erase_cnt + 1;
        if (flash_program || flash_erase)
            last_addr <= flash_block_addr;
    end
endmodule // flash_array_model

// ### verification/table_access_flash_sequencer_tb_top.sv
// Self-checking bench for the flash sequencer.
// Assumes the array model beside it and a short long-cycle count.
`timescale 1ns/10ps

`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("[ERR] %s exp %0h got %0h", nm, e, g); \
        end \
    end

module table_access_flash_sequencer_tb_top;
    localparam int LC = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ext_reset_req = 1'b0, wdt_reset_req = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata;
    logic core_halt, cycle_done_irq_flag, flash_program, flash_erase;
    logic [20:0] flash_word_addr;
    logic [15:0] flash_word_data;
    logic [21:0] flash_block_addr, last_addr;
    logic [63:0] flash_block_data, last_data;
    int prog_cnt, erase_cnt;
    int compares = 0, miscompares = 0;

    table_access_flash_sequencer #(.LONG_CYCLES(LC)) u_table_access_flash_sequencer (.clk,
        .rst, .ext_reset_req, .wdt_reset_req, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_halt, .cycle_done_irq_flag,
        .flash_word_addr, .flash_word_data, .flash_program, .flash_erase, .flash_block_addr,
        .flash_block_data);

    flash_array_model u_flash_array_model (.clk, .flash_word_addr, .flash_word_data,
        .flash_program, .flash_erase, .flash_block_addr, .flash_block_data, .prog_cnt,
        .erase_cnt, .last_addr, .last_data);

    always #25 clk = ~clk;

    // ----------------------------------------
    // Bus cycles and helpers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        resp = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    task automatic setp(input logic [21:0] p);
        wr(8'h00, {24'h0, p[7:0]});
        wr(8'h04, {24'h0, p[15:8]});
        wr(8'h08, {26'h0, p[21:16]});
    endtask

    task automatic rdp(output logic [21:0] p);
        logic [31:0] l, h, u;
        rd(8'h00, l);
        rd(8'h04, h);
        rd(8'h08, u);
        p = {u[5:0], h[7:0], l[7:0]};
    endtask

    // Unlock keys then start; a key write of any other kind breaks it
    task automatic launch(input logic [31:0] c);
        wr(8'h10, c);
        wr(8'h14, 32'h55);
        wr(8'h14, 32'hAA);
        wr(8'h10, c | 32'h2);
    endtask

    task automatic wait_idle();
        do
            @(posedge clk);
        while (core_halt);
    endtask

    function automatic logic [21:0] stepp(input logic [21:0] p, input int d);
        logic [20:0] l;
        l = p[20:0] + 21'(d);
        return {p[21], l};
    endfunction

    function automatic logic [7:0] exp_byte(input logic [21:0] a);
        return a[0] ? ~a[8:1] : a[8:1];
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_regs();
        logic [31:0] d;
        logic [21:0] p;
        rdp(p);
        `CHK("ptr reset", 22'h0, p)
        wr(8'h00, 32'hA5);
        wr(8'h04, 32'h5A);
        wr(8'h08, 32'hFF);
        rdp(p);
        `CHK("ptr join", 22'h3F5AA5, p)
        wr(8'h20, 32'h0);
        `CHK("unmapped", 2'h2, resp)
        rd(8'h14, d);
        `CHK("key reads", 32'h0, d)
        rd(8'h20, d);
        `CHK("unmapped rd", 2'h2, resp)
    endtask

    task automatic s_fetch();
        logic [31:0] d;
        logic [21:0] p, p0, ea, en;
        for (int s = 0; s < 2; s++)
        begin
            for (int m = 0; m < 4; m++)
            begin
                p0 = (s == 1) ? 22'h200000 : 22'h3FFFFF;
                ea = (m == 3) ? stepp(p0, 1) : p0;
                en = (m == 0) ? p0 : (m == 2) ? stepp(p0, -1) : stepp(p0, 1);
                setp(p0);
                wr(8'h18, 32'(m));
                rd(8'h0C, d);
                `CHK("latch", exp_byte(ea), d[7:0])
                rdp(p);
                `CHK("ptr step", en, p)
                `CHK("space bit", p0[21], p[21])
            end
        end
    endtask

    task automatic s_program();
        logic [31:0] d;
        logic [63:0] e;
        int n;
        n = prog_cnt;
        setp(22'h000043);
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h0C, 32'(8'h10 + i));
            wr(8'h18, 32'h5);
            e[8 * ((3 + i) % 8) +: 8] = 8'(8'h10 + i);
        end
        `CHK("store quiet", n, prog_cnt)
        launch(32'h84);
        wait_idle();
        `CHK("prog count", n + 1, prog_cnt)
        `CHK("prog addr", 22'h000048, last_addr)
        `CHK("prog data", e, last_data)
        rd(8'h1C, d);
        `CHK("done flag", 1'b1, d[0])
        rd(8'h10, d);
        `CHK("start clear", 32'h84, d)
    endtask

    task automatic s_erase();
        logic [31:0] d;
        int n;
        n = erase_cnt;
        setp(22'h00017F);
        launch(32'h94);
        wait_idle();
        `CHK("erase count", n + 1, erase_cnt)
        `CHK("erase addr", 22'h000140, last_addr)
        rd(8'h10, d);
        `CHK("row bit clear", 32'h84, d)
        wr(8'h1C, 32'h1);
        rd(8'h1C, d);
        `CHK("done cleared", 1'b0, d[0])
        launch(32'h14);
        wait_idle();
        `CHK("no erase unsel", n + 1, erase_cnt)
    endtask

    task automatic s_unlock();
        logic [31:0] d;
        int n;
        n = prog_cnt + erase_cnt;
        wr(8'h10, 32'h84);
        wr(8'h14, 32'h55);
        wr(8'h00, 32'h0);
        wr(8'h14, 32'hAA);
        wr(8'h10, 32'h86);
        rd(8'h10, d);
        `CHK("broken keys", 1'b0, d[1])
        wr(8'h14, 32'hAA);
        wr(8'h14, 32'h55);
        wr(8'h10, 32'h86);
        rd(8'h10, d);
        `CHK("key order", 1'b0, d[1])
        launch(32'h80);
        rd(8'h10, d);
        `CHK("no permit", 1'b0, d[1])
        `CHK("no cycle", n, prog_cnt + erase_cnt)
    endtask

    task automatic s_abort();
        logic [31:0] d;
        for (int i = 0; i < 2; i++)
        begin
            launch(32'h84);
            repeat (3) @(posedge clk);
            ext_reset_req <= (i == 0);
            wdt_reset_req <= (i == 1);
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            ext_reset_req <= 1'b0;
            wdt_reset_req <= 1'b0;
            rst <= 1'b0;
            @(posedge clk);
            rd(8'h10, d);
            `CHK("aborted", 32'h08, d)
            wr(8'h10, 32'h0);
            rd(8'h10, d);
            `CHK("abort clear", 32'h0, d)
        end
    endtask

    task automatic print_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_regs();
        s_fetch();
        s_program();
        s_erase();
        s_unlock();
        s_abort();
        print_verdict();
    end

    // Whole run needs several hundred cycles
    initial
    begin
        #(50 * 20000);
        miscompares++;
        print_verdict();
    end
endmodule // table_access_flash_sequencer_tb_top
